/* File: core/epc_map.svh */
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
// Control register index 0x1d; bus byte address = 4 * index, compared as a word index
`define EPC_CTRL_INDEX 12'h001d
`define EPC_CTRL_ADDR 14'h001d
// Window of the array, byte addresses on the bus
`define EPC_ARRAY_BASE 16'h2000
`define EPC_ARRAY_TOP 16'h3fff
// Status register, word index of byte address 0x78
`define EPC_STAT_ADDR 14'h001e

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EPC_PWR_POS 0
`define EPC_LATCH_POS 2
`define EPC_CTRL_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define EPC_CLK_MHZ 250
`define EPC_PULSE_TIME_US 4000
`define EPC_PULSE_CYCLES (`EPC_PULSE_TIME_US * `EPC_CLK_MHZ)

`endif

/* File: core/epc_pkg.sv */
package epc_pkg;

   typedef enum logic [1:0] {
      EPC_IDLE = 2'b00,
      EPC_LOAD = 2'b01,
      EPC_BURN = 2'b10
   } epc_phase_t;

   typedef logic [7:0] epc_byte_t;

endpackage : epc_pkg

/* File: core/epc_latch.sv */
`timescale 1ns/1ns
`include "epc_map.svh"

module epc_latch
   import epc_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Capture request
   input wire logic latch_on,
   input wire logic cap_we,
   input wire logic [ADDR_W-1:0] cap_addr,
   input wire logic [3:0] cap_sel,
   input wire logic [31:0] cap_data,
   // Latched programming word
   output logic [ADDR_W-3:0] blk_addr_reg,
   output logic [31:0] blk_data_reg,
   output logic [3:0] blk_mask_reg,
   output logic blk_err_reg
);

   logic [3:0] mask_next;
   logic err_next;
   wire logic same_blk;
   wire logic first;

   assign first = (blk_mask_reg == 4'h0);
   assign same_blk = first || (cap_addr[ADDR_W-1:2] == blk_addr_reg);
   assign mask_next = blk_mask_reg | cap_sel;
   assign err_next = blk_err_reg || !same_blk;

   // ----------------------------------------
   // Address and data capture
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !latch_on) begin
         blk_addr_reg <= '0;
         blk_data_reg <= 32'h0000_0000;
         blk_mask_reg <= 4'h0;
         blk_err_reg <= 1'b0;
      end else if (cap_we && same_blk) begin
         blk_addr_reg <= cap_addr[ADDR_W-1:2];
         for (int i = 0; i < 4; i++) begin
            if (cap_sel[i]) begin
               blk_data_reg[8*i +: 8] <= cap_data[8*i +: 8];
            end
         end
         blk_mask_reg <= mask_next;
      end else if (cap_we) begin
         blk_err_reg <= err_next;
      end
   end

endmodule : epc_latch

/* File: core/epc_timer.sv */
`timescale 1ns/1ns
`include "epc_map.svh"

module epc_timer
   import epc_pkg::*;
#(
   parameter int PULSE_CYCLES = `EPC_PULSE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Power level
   input wire logic pwr_on,
   // Elapsed flag
   output logic done_reg
);

   localparam int CW = $clog2(PULSE_CYCLES + 1);
   logic [CW-1:0] cnt_reg;
   wire logic at_end;

   assign at_end = (cnt_reg == CW'(PULSE_CYCLES));

   // ----------------------------------------
   // Pulse length counter
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !pwr_on) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else if (!at_end) begin
         cnt_reg <= cnt_reg + CW'(1);
         done_reg <= (cnt_reg == CW'(PULSE_CYCLES - 1));
      end
   end

endmodule : epc_timer

/* File: core/epc_ctrl.sv */
`timescale 1ns/1ns
`include "epc_map.svh"

// Function
// - Power bit set routes programming power to the array; clear disconnects it.
// - A write setting latch and power together leaves power clear.
// - Power bit can only be set while latch bit already reads one.
// - Clearing the latch bit clears the power bit in the same update.
// - Latch set selects programming paths; clear selects ordinary reads.
// - Array writes with latch set capture address and data for programming.
// - Array reads with latch set return no valid contents.
// - Up to four bytes latch together only within one aligned 4-byte block.
module epc_ctrl
   import epc_pkg::*;
#(
   parameter int ADDR_W = 14,
   parameter int PULSE_CYCLES = `EPC_PULSE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Array read port
   output logic [ADDR_W-1:0] arr_rd_addr_reg,
   input wire logic [31:0] arr_rd_data,
   // Array programming port
   output logic eprom_program_control_mode_reg,
   output logic eprom_program_control_power_reg,
   output logic [ADDR_W-3:0] eprom_program_control_addr_reg,
   output logic [31:0] eprom_program_control_data_reg,
   output logic [3:0] eprom_program_control_mask_reg
);

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic latch_enable_bit_reg;
   logic program_power_bit_reg;
   logic latch_next;
   logic power_next;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic rd_pend_reg;
   epc_phase_t phase_reg;
   epc_phase_t phase_next;

   wire logic req;
   wire logic hit_ctrl;
   wire logic hit_stat;
   wire logic hit_arr;
   wire logic wr_ctrl;
   wire logic wr_lo;
   wire logic w_latch;
   wire logic w_power;
   wire logic arr_wr;
   wire logic [ADDR_W-3:0] blk_addr;
   wire logic [31:0] blk_data;
   wire logic [3:0] blk_mask;
   wire logic blk_err;
   wire logic pulse_done;
   wire logic [31:0] ctrl_rd;
   wire logic [31:0] stat_rd;
   wire logic [31:0] rd_mux;

   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign hit_ctrl = (wb_adr_i[15:2] == `EPC_CTRL_ADDR);
   assign hit_stat = (wb_adr_i[15:2] == `EPC_STAT_ADDR);
   assign hit_arr = (wb_adr_i >= `EPC_ARRAY_BASE) && (wb_adr_i <= `EPC_ARRAY_TOP);
   assign wr_lo = wb_sel_i[0];
   assign wr_ctrl = req && wb_we_i && hit_ctrl && wr_lo;
   assign w_latch = wb_dat_i[`EPC_LATCH_POS];
   assign w_power = wb_dat_i[`EPC_PWR_POS];
   // only latched mode lets a write reach the capture logic
   assign arr_wr = req && wb_we_i && hit_arr && latch_enable_bit_reg;

   // Next control state
   always_comb begin
      latch_next = latch_enable_bit_reg;
      power_next = program_power_bit_reg;
      if (wr_ctrl) begin
         latch_next = w_latch;
         // Power taken only if latch was already set and stays set
         power_next = w_power && latch_enable_bit_reg && w_latch;
      end
   end

   // Phase of a programming sequence, for status
   always_comb begin
      phase_next = EPC_IDLE;
      if (latch_next && power_next) begin
         phase_next = EPC_BURN;
      end else if (latch_next) begin
         phase_next = EPC_LOAD;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         latch_enable_bit_reg <= 1'b0;
         program_power_bit_reg <= 1'b0;
         phase_reg <= EPC_IDLE;
      end else begin
         latch_enable_bit_reg <= latch_next;
         program_power_bit_reg <= power_next;
         phase_reg <= phase_next;
      end
   end

   // ----------------------------------------
   // Latches and pulse timer
   // ----------------------------------------
   epc_latch #(
      .ADDR_W(ADDR_W)
   ) u_latch (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .latch_on(latch_enable_bit_reg),
      .cap_we(arr_wr),
      .cap_addr(wb_adr_i[ADDR_W-1:0]),
      .cap_sel(wb_sel_i),
      .cap_data(wb_dat_i),
      .blk_addr_reg(blk_addr),
      .blk_data_reg(blk_data),
      .blk_mask_reg(blk_mask),
      .blk_err_reg(blk_err)
   );

   epc_timer #(
      .PULSE_CYCLES(PULSE_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pwr_on(program_power_bit_reg),
      .done_reg(pulse_done)
   );

   // ----------------------------------------
   // Programming outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         eprom_program_control_mode_reg <= 1'b0;
         eprom_program_control_power_reg <= 1'b0;
         eprom_program_control_addr_reg <= '0;
         eprom_program_control_data_reg <= 32'h0000_0000;
         eprom_program_control_mask_reg <= 4'h0;
      end else begin
         eprom_program_control_mode_reg <= latch_enable_bit_reg;
         eprom_program_control_power_reg <= program_power_bit_reg;
         eprom_program_control_addr_reg <= blk_addr;
         eprom_program_control_data_reg <= blk_data;
         // Lanes drop together with the mode so no mask is shown outside programming
         eprom_program_control_mask_reg <= latch_enable_bit_reg ? blk_mask : 4'h0;
      end
   end

   // ----------------------------------------
   // Read path and acknowledge
   // ----------------------------------------
   assign ctrl_rd = {29'h0000_0000, latch_enable_bit_reg, 1'b0, program_power_bit_reg};
   assign stat_rd = {24'h0000_00, pulse_done, blk_err, phase_reg, blk_mask};
   // Array contents are hidden while latched
   assign rd_mux = latch_enable_bit_reg ? 32'h0000_0000 : arr_rd_data;

   // Array reads take one extra cycle for the registered address
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         arr_rd_addr_reg <= '0;
         rd_pend_reg <= 1'b0;
      end else begin
         if (req && !wb_we_i && hit_arr && !rd_pend_reg) begin
            arr_rd_addr_reg <= wb_adr_i[ADDR_W-1:0];
         end
         rd_pend_reg <= req && !wb_we_i && hit_arr && !rd_pend_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req && !(hit_arr && !wb_we_i && !rd_pend_reg);
         if (req && !wb_we_i) begin
            dat_reg <= hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : hit_arr ? rd_mux : 32'h0000_0000;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

endmodule : epc_ctrl

/* File: test/epc_checker.sv */
`timescale 1ns/1ns
module epc_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Programming port
   input wire logic eprom_program_control_mode_reg,
   input wire logic eprom_program_control_power_reg,
   input wire logic [3:0] eprom_program_control_mask_reg
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire logic in_arr = wb_adr_i >= 16'h2000 && wb_adr_i <= 16'h3fff;
   wire logic ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == 16'h0074;
   // ----------------
   // Properties
   // ----------------
   a_pwr_needs_latch: assert property (eprom_program_control_power_reg |-> eprom_program_control_mode_reg)
      else $error("power without latch");
   a_no_joint_set: assert property ($rose(eprom_program_control_power_reg) |-> $past(eprom_program_control_mode_reg))
      else $error("power set with latch");
   a_latch_drop_pwr: assert property ($fell(eprom_program_control_mode_reg) |-> !eprom_program_control_power_reg)
      else $error("power left on");
   a_pwr_by_write: assert property ($rose(eprom_program_control_power_reg) |-> $past(ctl_wr))
      else $error("power rose unasked");
   a_mode_by_write: assert property ($rose(eprom_program_control_mode_reg) |-> $past(ctl_wr))
      else $error("latch rose unasked");
   a_locked_read: assert property (wb_ack_o && !wb_we_i && in_arr && eprom_program_control_mode_reg |-> wb_dat_o == 32'h0000_0000)
      else $error("array readable while latched");
   a_clear_latches: assert property (!eprom_program_control_mode_reg |-> eprom_program_control_mask_reg == 4'h0)
      else $error("lanes held without latch");
   a_ack_bound: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
      else $error("no ack");
endmodule : epc_checker

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
   logic sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic eprom_program_control_mode_reg, eprom_program_control_power_reg;
   logic [15:0] wb_adr_i;
   logic [3:0] wb_sel_i, eprom_program_control_mask_reg;
   logic [31:0] wb_dat_i, wb_dat_o, arr_rd_data, eprom_program_control_data_reg, rd;
   logic [13:0] arr_rd_addr_reg;
   logic [11:0] eprom_program_control_addr_reg;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   // Array contents follow the address
   assign arr_rd_data = {2'b00, arr_rd_addr_reg, 16'h5a5a};
   epc_ctrl #(.PULSE_CYCLES(20)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .arr_rd_addr_reg(arr_rd_addr_reg), .arr_rd_data(arr_rd_data),
      .eprom_program_control_mode_reg(eprom_program_control_mode_reg), .eprom_program_control_power_reg(eprom_program_control_power_reg),
      .eprom_program_control_addr_reg(eprom_program_control_addr_reg), .eprom_program_control_data_reg(eprom_program_control_data_reg), .eprom_program_control_mask_reg(eprom_program_control_mask_reg));
   // ----------------
   // Tasks
   // ----------------
   task automatic summarize;
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // One classic cycle; returns one edge after ack
   task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask : wb
   task automatic t_reset;
      chk("outs", 32'h0000_0000, {eprom_program_control_mode_reg, eprom_program_control_power_reg, eprom_program_control_mask_reg});
      wb(1'b0, 16'h0074, 32'h0000_0000, 4'hf);
      chk("ctrl", 32'h0000_0000, rd);
      wb(1'b0, 16'h2104, 32'h0000_0000, 4'hf);
      chk("arr", 32'h2104_5a5a, rd);
      wb(1'b0, 16'h0040, 32'h0000_0000, 4'hf);
      chk("unmapped", 32'h0000_0000, rd);
   endtask : t_reset
   task automatic t_idle_write;
      wb(1'b1, 16'h2100, 32'h0000_00aa, 4'h1);
      chk("mask", 32'h0000_0000, eprom_program_control_mask_reg);
      wb(1'b1, 16'h0074, 32'h0000_0001, 4'h1);
      chk("pwr", 32'h0000_0000, eprom_program_control_power_reg);
   endtask : t_idle_write
   task automatic t_joint;
      wb(1'b1, 16'h0074, 32'h0000_0005, 4'h1);
      chk("joint", 32'h0000_0002, {eprom_program_control_mode_reg, eprom_program_control_power_reg});
      wb(1'b0, 16'h0074, 32'h0000_0000, 4'hf);
      chk("ctrl", 32'h0000_0004, rd);
   endtask : t_joint
   task automatic t_burn;
      wb(1'b1, 16'h2100, 32'h0000_1100, 4'h2);
      wb(1'b1, 16'h2100, 32'h3300_0000, 4'h8);
      wb(1'b1, 16'h2104, 32'h0000_00ee, 4'h1);
      chk("blk", 32'h0000_0840, eprom_program_control_addr_reg);
      chk("mask", 32'h0000_000a, eprom_program_control_mask_reg);
      chk("data", 32'h3300_1100, eprom_program_control_data_reg & 32'hff00_ff00);
      wb(1'b0, 16'h2100, 32'h0000_0000, 4'hf);
      chk("locked", 32'h0000_0000, rd);
      wb(1'b1, 16'h0074, 32'h0000_0005, 4'h1);
      chk("pwr on", 32'h0000_0003, {eprom_program_control_mode_reg, eprom_program_control_power_reg});
      // Pulse not yet elapsed a few cycles after power on
      wb(1'b0, 16'h0078, 32'h0000_0000, 4'hf);
      chk("stat early", 32'h0000_006a, rd);
      repeat (25) @(posedge sys_clk);
      wb(1'b0, 16'h0078, 32'h0000_0000, 4'hf);
      chk("stat", 32'h0000_00ea, rd);
      wb(1'b1, 16'h0074, 32'h0000_0000, 4'h1);
      chk("clear", 32'h0000_0000, {eprom_program_control_mode_reg, eprom_program_control_power_reg, eprom_program_control_mask_reg});
   endtask : t_burn
   // ----------------
   // Run
   // ----------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         summarize;
      end
   end
   initial begin
      rst_b = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 16'h0000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_idle_write;
      t_joint;
      t_burn;
      summarize;
   end
endmodule : testbench
bind epc_ctrl epc_checker chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .eprom_program_control_mode_reg(eprom_program_control_mode_reg), .eprom_program_control_power_reg(eprom_program_control_power_reg),
   .eprom_program_control_mask_reg(eprom_program_control_mask_reg));
